//--- rtl/vrc_pkg.sv
// Constants and types for the ranged record/erase command handler.
// Assumes one 100 MHz clock and a serial host on pins sampled by it.
package vrc_pkg;
  // Opcodes of the serial commands
  localparam logic [7:0] OP_RANGED_RECORD_CMD = 8'h81;
  localparam logic [7:0] OP_SET_ERASE = 8'h82;
  localparam logic [7:0] OP_EXT_CLK = 8'h4a;
  localparam logic [7:0] OP_STOP = 8'h02;
  localparam logic [7:0] OP_RESET = 8'h03;
  localparam logic [7:0] OP_INTERRUPT_CLEAR_CMD = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_PWR_DOWN = 8'h07;
  // Frame lengths and byte positions
  localparam logic [2:0] LEN_SET = 3'h7;
  localparam logic [2:0] LEN_TWO = 3'h2;
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] BYTE_OP = 3'h0;
  localparam logic [2:0] BYTE_S_LO = 3'h2;
  localparam logic [2:0] BYTE_S_HI = 3'h3;
  localparam logic [2:0] BYTE_E_LO = 3'h4;
  localparam logic [2:0] BYTE_E_HI = 3'h5;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Row space
  localparam logic [10:0] FIRST_USER_ROW = 11'h010;
  localparam logic [10:0] LAST_ROW = 11'h7ff;
  // External timebase clocks per audio sample
  localparam int CLKS_PER_SAMPLE = 256;
  // Status byte returned on MISO
  localparam int SR0_CMD_ERR = 0;
  localparam int SR0_INT = 4;
  // APB map
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_CMD_ERR = 1;
  localparam int ST_ERASE_BIT = 16;
  localparam int ST_REC_BIT = 17;
  localparam int ST_QUEUE_BIT = 18;
  localparam int ST_READY_BIT = 19;
  localparam int ST_EXT_BIT = 20;
  typedef enum logic [1:0] {ST_IDLE, ST_REC, ST_ERASE} mode_t;
endpackage

//--- rtl/vrc_cmd.sv
// Command handler for ranged record, ranged erase and timebase toggle.
// Assumes a serial host on SPI pins (mode 0, LSB first), APB master on CLK,
// and a row memory that acts on the row strobes.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps

// Contract
// - Set frame: opcode, zero, start low, start high, end low, end high, zero.
// - Ranged record writes rows from latched start through end, 11-bit addresses.
// - Recording accepts only record, stop, reset, clear, status, power down.
// - Ready stays low until addresses latched and recording has begun.
// - Without queued pair, record ends at end row with end marker.
// - Second record after ready is queued without disturbing current one.
// - With a queued pair, no end marker; continue at queued start.
// - Ranged erase uses same frame, erases start through end inclusive.
// - Erasing accepts only reset, clear, status, power down; else error.
// - Ready stays low during erase, then an interrupt is raised.
// - Two-byte toggle from idle flips timebase mode, no interrupt.
// - External mode stops internal oscillator, uses resistor-pin clock.
// - Reset command or reset pin clears external timebase mode.
// - Any external clock duty cycle works; edges are conditioned inside.
// - End below start wraps from last row to row 0x010.
// - Interrupt status holds until the interrupt clear command.
module vrc_cmd #(
  parameter int OSC_DIV = 49,
  parameter int SAMPLES_PER_ROW = 8
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic SPI_SCLK,
  input wire logic SPI_MOSI,
  input wire logic SPI_SS_N,
  output logic SPI_MISO,
  output logic SPI_MISO_OE_N,
  input wire logic ROSC_CLK,
  output logic [10:0] ROW_ADDR,
  output logic ROW_WRITE,
  output logic ROW_ERASE,
  output logic ROW_EOM,
  output logic READY,
  output logic INT_FLAG,
  output logic EXT_MODE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ
);
  localparam int ROW_TICKS = vrc_pkg::CLKS_PER_SAMPLE * SAMPLES_PER_ROW;
  localparam int RC_W = $clog2(ROW_TICKS);
  localparam int OC_W = $clog2(OSC_DIV);

  if (OSC_DIV < 2 || SAMPLES_PER_ROW < 1) begin : g_chk
    $error("vrc_cmd: OSC_DIV must be 2 or more, SAMPLES_PER_ROW 1 or more");
  end

  function automatic logic [10:0] next_row(input logic [10:0] r);
    next_row = (r == vrc_pkg::LAST_ROW) ? vrc_pkg::FIRST_USER_ROW : r + 11'h001;
  endfunction

  function automatic logic [2:0] cmd_len(input logic [7:0] op);
    case (op)
      vrc_pkg::OP_RANGED_RECORD_CMD, vrc_pkg::OP_SET_ERASE: cmd_len = vrc_pkg::LEN_SET;
      vrc_pkg::OP_EXT_CLK: cmd_len = vrc_pkg::LEN_TWO;
      default: cmd_len = vrc_pkg::LEN_ONE;
    endcase
  endfunction

  function automatic logic allowed(input vrc_pkg::mode_t m, input logic [7:0] op);
    logic any;
    any = (op == vrc_pkg::OP_RESET) || (op == vrc_pkg::OP_INTERRUPT_CLEAR_CMD) ||
          (op == vrc_pkg::OP_RD_STATUS) || (op == vrc_pkg::OP_PWR_DOWN);
    case (m)
      vrc_pkg::ST_REC: allowed = any || op == vrc_pkg::OP_STOP || op == vrc_pkg::OP_RANGED_RECORD_CMD;
      vrc_pkg::ST_ERASE: allowed = any;
      default: allowed = 1'b1;
    endcase
  endfunction

  logic [2:0] sclk_s_ff, ss_s_ff, rosc_s_ff;
  logic [1:0] mosi_s_ff;
  logic [7:0] rx_sh_ff, tx_sh_ff, op_ff, s_lo_ff, e_lo_ff;
  logic [2:0] bit_cnt_ff, byte_cnt_ff, s_hi_ff, e_hi_ff;
  logic miso_ff, miso_oe_n_ff;
  vrc_pkg::mode_t mode_ff;
  logic [10:0] cur_ff, end_ff, qs_ff, qe_ff;
  logic q_valid_ff, pend_ff, ready_ff, wr_ff, er_ff, eom_ff;
  logic cmd_err_ff, int_ff, ext_ff;
  logic [OC_W-1:0] osc_cnt_ff;
  logic osc_tick_ff;
  logic [RC_W-1:0] row_cnt_ff;
  logic [vrc_pkg::IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
  logic irq_ff, pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic [10:0] row_addr_ff;
  logic [7:0] sr0;
  logic [31:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sclk_s_ff <= 3'h0;
      ss_s_ff <= 3'h7;
      rosc_s_ff <= 3'h0;
      mosi_s_ff <= 2'h0;
    end else begin
      sclk_s_ff <= {sclk_s_ff[1:0], SPI_SCLK};
      ss_s_ff <= {ss_s_ff[1:0], SPI_SS_N};
      rosc_s_ff <= {rosc_s_ff[1:0], ROSC_CLK};
      mosi_s_ff <= {mosi_s_ff[0], SPI_MOSI};
    end
  end

  wire in_frame = ~ss_s_ff[1];
  wire ss_fall = ~ss_s_ff[1] & ss_s_ff[2];
  wire ss_rise = ss_s_ff[1] & ~ss_s_ff[2];
  wire sclk_rise = sclk_s_ff[1] & ~sclk_s_ff[2] & in_frame;
  wire sclk_fall = ~sclk_s_ff[1] & sclk_s_ff[2] & in_frame;
  wire rosc_rise = rosc_s_ff[1] & ~rosc_s_ff[2];
  wire [7:0] rx_byte = {mosi_s_ff[1], rx_sh_ff[7:1]};
  wire byte_done = sclk_rise & (bit_cnt_ff == vrc_pkg::BIT_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Serial receive and frame capture
  always_ff @(posedge CLK) begin
    if (!RESET_N || ss_fall) begin
      rx_sh_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      byte_cnt_ff <= 3'h0;
    end else if (sclk_rise) begin
      rx_sh_ff <= rx_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (byte_done && byte_cnt_ff != vrc_pkg::LEN_SET) begin
        byte_cnt_ff <= byte_cnt_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      op_ff <= 8'h00;
      s_lo_ff <= 8'h00;
      s_hi_ff <= 3'h0;
      e_lo_ff <= 8'h00;
      e_hi_ff <= 3'h0;
    end else if (byte_done) begin
      case (byte_cnt_ff)
        vrc_pkg::BYTE_OP: op_ff <= rx_byte;
        vrc_pkg::BYTE_S_LO: s_lo_ff <= rx_byte;
        vrc_pkg::BYTE_S_HI: s_hi_ff <= rx_byte[2:0];
        vrc_pkg::BYTE_E_LO: e_lo_ff <= rx_byte;
        vrc_pkg::BYTE_E_HI: e_hi_ff <= rx_byte[2:0];
        default: op_ff <= op_ff;
      endcase
    end
  end

  always_comb begin
    sr0 = 8'h00;
    sr0[vrc_pkg::SR0_CMD_ERR] = cmd_err_ff;
    sr0[vrc_pkg::SR0_INT] = int_ff;
  end

  // Status byte out, reloaded at every byte boundary
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      tx_sh_ff <= 8'h00;
      miso_ff <= 1'b0;
      miso_oe_n_ff <= 1'b1;
    end else begin
      miso_oe_n_ff <= ss_s_ff[1];
      if (ss_fall || (sclk_fall && bit_cnt_ff == 3'h0)) begin
        miso_ff <= sr0[0];
        tx_sh_ff <= {1'b0, sr0[7:1]};
      end else if (sclk_fall) begin
        miso_ff <= tx_sh_ff[0];
        tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode at frame end
  wire cmd_go = ss_rise & (byte_cnt_ff >= cmd_len(op_ff));
  wire ok = allowed(mode_ff, op_ff);
  wire accept = cmd_go & ok;
  wire bad = cmd_go & ~ok;
  wire idle = mode_ff == vrc_pkg::ST_IDLE;
  wire recing = mode_ff == vrc_pkg::ST_REC;
  wire [10:0] s_addr = {s_hi_ff, s_lo_ff};
  wire [10:0] e_addr = {e_hi_ff, e_lo_ff};
  wire is_rec = op_ff == vrc_pkg::OP_RANGED_RECORD_CMD;
  wire start_rec = accept & is_rec & idle & ready_ff;
  wire start_era = accept & (op_ff == vrc_pkg::OP_SET_ERASE) & idle & ready_ff;
  wire queue_rec = accept & is_rec & recing & ready_ff & ~q_valid_ff;
  wire abort = accept & ~idle & ((op_ff == vrc_pkg::OP_STOP) |
               (op_ff == vrc_pkg::OP_RESET) | (op_ff == vrc_pkg::OP_PWR_DOWN));
  wire ext_tog = accept & (op_ff == vrc_pkg::OP_EXT_CLK) & idle;
  wire reset_cmd = accept & (op_ff == vrc_pkg::OP_RESET);
  wire interrupt_clear_cmd = accept & (op_ff == vrc_pkg::OP_INTERRUPT_CLEAR_CMD);

  ////////////////////////////////////////////////////////////////////////////
  // Timebase: internal divider or conditioned external clock
  always_ff @(posedge CLK) begin
    if (!RESET_N || ext_ff) begin
      osc_cnt_ff <= '0;
      osc_tick_ff <= 1'b0;
    end else begin
      osc_tick_ff <= osc_cnt_ff == OC_W'(OSC_DIV - 1);
      osc_cnt_ff <= (osc_cnt_ff == OC_W'(OSC_DIV - 1)) ? '0 : osc_cnt_ff + 1'b1;
    end
  end

  // internal divider ticks or external clock edges feed the row timer, by timebase mode
  wire tb_tick = ext_ff ? rosc_rise : osc_tick_ff;
  wire row_done = ~idle & tb_tick & (row_cnt_ff == RC_W'(ROW_TICKS - 1));
  wire at_end = row_done & (cur_ff == end_ff);
  wire chain = recing & (q_valid_ff | queue_rec);
  wire fin = at_end & ~chain & ~abort;

  always_ff @(posedge CLK) begin
    if (!RESET_N || idle || start_rec || start_era) begin
      row_cnt_ff <= '0;
    end else if (tb_tick) begin
      row_cnt_ff <= (row_cnt_ff == RC_W'(ROW_TICKS - 1)) ? '0 : row_cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ranged operation sequencer
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      mode_ff <= vrc_pkg::ST_IDLE;
      cur_ff <= 11'h000;
      end_ff <= 11'h000;
      qs_ff <= 11'h000;
      qe_ff <= 11'h000;
      q_valid_ff <= 1'b0;
      pend_ff <= 1'b0;
      ready_ff <= 1'b1;
      wr_ff <= 1'b0;
      er_ff <= 1'b0;
      eom_ff <= 1'b0;
    end else begin
      wr_ff <= 1'b0;
      er_ff <= 1'b0;
      eom_ff <= 1'b0;
      if (start_rec || start_era) begin
        mode_ff <= start_rec ? vrc_pkg::ST_REC : vrc_pkg::ST_ERASE;
        cur_ff <= s_addr;
        end_ff <= e_addr;
        pend_ff <= 1'b1;
        ready_ff <= 1'b0;
      end
      if (pend_ff && tb_tick) begin
        pend_ff <= 1'b0;
        ready_ff <= recing;
      end
      if (queue_rec) begin
        qs_ff <= s_addr;
        qe_ff <= e_addr;
        q_valid_ff <= 1'b1;
        ready_ff <= 1'b0;
      end
      if (row_done) begin
        wr_ff <= recing;
        er_ff <= ~recing;
        if (at_end && chain) begin
          cur_ff <= q_valid_ff ? qs_ff : s_addr;
          end_ff <= q_valid_ff ? qe_ff : e_addr;
          q_valid_ff <= 1'b0;
          ready_ff <= 1'b1;
        end else if (at_end) begin
          eom_ff <= recing;
          mode_ff <= vrc_pkg::ST_IDLE;
          ready_ff <= 1'b1;
        end else begin
          cur_ff <= next_row(cur_ff);
        end
      end
      if (abort) begin
        eom_ff <= recing;
        mode_ff <= vrc_pkg::ST_IDLE;
        q_valid_ff <= 1'b0;
        pend_ff <= 1'b0;
        ready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      row_addr_ff <= 11'h000;
    end else begin
      row_addr_ff <= cur_ff;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      cmd_err_ff <= 1'b0;
    end else if (bad) begin
      cmd_err_ff <= 1'b1;
    end else if (accept && op_ff != vrc_pkg::OP_RD_STATUS) begin
      cmd_err_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      int_ff <= 1'b0;
    end else if (fin) begin
      int_ff <= 1'b1;
    end else if (interrupt_clear_cmd) begin
      int_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N || reset_cmd) begin
      ext_ff <= 1'b0;
    end else if (ext_tog) begin
      ext_ff <= ~ext_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: interrupt status, mask and state readback
  wire acc = PSEL & PENABLE & ~pready_ff;
  wire wr_xfer = PSEL & PENABLE & pready_ff & PWRITE;
  wire hit = (PADDR == vrc_pkg::ADDR_IRQ_STAT) | (PADDR == vrc_pkg::ADDR_IRQ_MASK) |
             (PADDR == vrc_pkg::ADDR_STATE);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (PADDR)
      vrc_pkg::ADDR_IRQ_STAT: rd_word[vrc_pkg::IRQ_W-1:0] = irq_stat_ff;
      vrc_pkg::ADDR_IRQ_MASK: rd_word[vrc_pkg::IRQ_W-1:0] = irq_mask_ff;
      vrc_pkg::ADDR_STATE: begin
        rd_word[10:0] = cur_ff;
        rd_word[vrc_pkg::ST_ERASE_BIT] = mode_ff == vrc_pkg::ST_ERASE;
        rd_word[vrc_pkg::ST_REC_BIT] = recing;
        rd_word[vrc_pkg::ST_QUEUE_BIT] = q_valid_ff;
        rd_word[vrc_pkg::ST_READY_BIT] = ready_ff;
        rd_word[vrc_pkg::ST_EXT_BIT] = ext_ff;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc & ~hit;
      if (acc) begin
        prdata_ff <= PWRITE ? 32'h0000_0000 : rd_word;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~((wr_xfer && PADDR == vrc_pkg::ADDR_IRQ_STAT) ?
                      PWDATA[vrc_pkg::IRQ_W-1:0] : '0)) | {bad, fin};
      if (wr_xfer && PADDR == vrc_pkg::ADDR_IRQ_MASK) begin
        irq_mask_ff <= PWDATA[vrc_pkg::IRQ_W-1:0];
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign SPI_MISO = miso_ff;
  assign SPI_MISO_OE_N = miso_oe_n_ff;
  assign ROW_ADDR = row_addr_ff;
  assign ROW_WRITE = wr_ff;
  assign ROW_ERASE = er_ff;
  assign ROW_EOM = eom_ff;
  assign READY = ready_ff;
  assign INT_FLAG = int_ff;
  assign EXT_MODE = ext_ff;
  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign IRQ = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_rec_row_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    row_done && recing |=> wr_ff && row_addr_ff == $past(cur_ff))
    else $error("record row not written");
  a_rec_bad_cmd: assert property (@(posedge CLK) disable iff (!RESET_N)
    cmd_go && recing && op_ff == vrc_pkg::OP_SET_ERASE |=> cmd_err_ff)
    else $error("bad command in record not flagged");
  a_ready_pend: assert property (@(posedge CLK) disable iff (!RESET_N)
    start_rec |=> !ready_ff ##1 (ready_ff == $past(tb_tick)))
    else $error("ready high before recording began");
  a_end_marker: assert property (@(posedge CLK) disable iff (!RESET_N)
    at_end && recing && !chain && !abort |=> eom_ff && idle && ready_ff)
    else $error("no end marker at end row");
  a_queue_keep: assert property (@(posedge CLK) disable iff (!RESET_N)
    queue_rec && !row_done |=> q_valid_ff && recing && $stable(cur_ff))
    else $error("queued pair disturbed record");
  a_chain_jump: assert property (@(posedge CLK) disable iff (!RESET_N)
    at_end && recing && q_valid_ff && !abort |=> !eom_ff && cur_ff == $past(qs_ff))
    else $error("queued start not taken");
  a_erase_bad: assert property (@(posedge CLK) disable iff (!RESET_N)
    cmd_go && mode_ff == vrc_pkg::ST_ERASE && op_ff == vrc_pkg::OP_STOP |=> cmd_err_ff)
    else $error("bad command in erase not flagged");
  a_erase_busy: assert property (@(posedge CLK) disable iff (!RESET_N)
    mode_ff == vrc_pkg::ST_ERASE |-> !ready_ff)
    else $error("ready high during erase");
  a_ext_toggle: assert property (@(posedge CLK) disable iff (!RESET_N)
    ext_tog |=> ext_ff != $past(ext_ff) && int_ff == $past(int_ff))
    else $error("timebase toggle wrong");
  a_osc_stop: assert property (@(posedge CLK) disable iff (!RESET_N)
    ext_ff |=> osc_cnt_ff == '0 && !osc_tick_ff)
    else $error("oscillator runs in external mode");
  a_reset_ext: assert property (@(posedge CLK) disable iff (!RESET_N)
    reset_cmd |=> !ext_ff)
    else $error("reset kept external mode");
  a_row_wrap: assert property (@(posedge CLK) disable iff (!RESET_N)
    row_done && cur_ff == vrc_pkg::LAST_ROW && !at_end && !abort
    |=> cur_ff == vrc_pkg::FIRST_USER_ROW)
    else $error("wrap row wrong");
  a_int_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
    int_ff && !interrupt_clear_cmd |=> int_ff)
    else $error("interrupt lost without clear");
endmodule

//--- verif/vrc_host.sv
// Serial host model: sends command frames, gathers status bytes, makes the timebase.
// Assumes mode 0, LSB first, a 160 ns serial clock that stands still between frames.
`timescale 1ns/100ps
module vrc_host (
  output logic sclk,
  output logic mosi,
  output logic ss_n,
  output logic rosc,
  input wire logic miso
);
  logic [7:0] last_sr0;
  logic [7:0] rx;
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
    rosc = 1'b0;
    last_sr0 = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // Whole frame, one select
  task automatic frame(input logic [55:0] f, input int n);
    ss_n = 1'b0;
    #83;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 8; k++) begin
        mosi = f[8*i+k];
        #80 sclk = 1'b1;
        rx[k] = miso;
        #80 sclk = 1'b0;
      end
      last_sr0 = rx;
    end
    #80 ss_n = 1'b1;
    mosi = ~mosi;
    #400;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Timebase pulses, uneven duty
  task automatic rosc_run(input int n);
    for (int i = 0; i < n; i++) begin
      #23 rosc = 1'b1;
      #42 rosc = 1'b0;
    end
  endtask
endmodule

//--- verif/vrc_cmd_tb.sv
// Testbench: serial commands, APB accesses and timebase; row strobes against a model.
// Assumes the handler built with one sample per row and a fast internal tick.
`timescale 1ns/100ps
module vrc_cmd_tb;
  logic clk, reset_n, sclk, mosi, ss_n, miso, rosc, ready, int_flag, ext_mode;
  logic row_write, row_erase, row_eom, psel, penable, pwrite, pready, pslverr, irq, err;
  logic miso_oe_n;
  logic [10:0] row_addr, s, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] seed = 32'h752cb6a8;
  logic [13:0] got_q[$];
  logic [13:0] exp_q[$];
  int n_errors = 0;
  int samples_checked = 0;
  initial clk = 1'b0;
  always #5 clk = ~clk;
  vrc_cmd #(.OSC_DIV(2), .SAMPLES_PER_ROW(1)) dut (.CLK(clk), .RESET_N(reset_n),
    .SPI_SCLK(sclk), .SPI_MOSI(mosi), .SPI_SS_N(ss_n), .SPI_MISO(miso),
    .SPI_MISO_OE_N(miso_oe_n),
    .ROSC_CLK(rosc), .ROW_ADDR(row_addr), .ROW_WRITE(row_write), .ROW_ERASE(row_erase),
    .ROW_EOM(row_eom), .READY(ready), .INT_FLAG(int_flag), .EXT_MODE(ext_mode),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
  // Undriven MISO shows the inverse, so a late enable corrupts the status byte
  vrc_host host (.sclk(sclk), .mosi(mosi), .ss_n(ss_n), .rosc(rosc),
    .miso(miso_oe_n ? ~miso : miso));
  always @(posedge clk) begin
    if (row_write | row_erase | row_eom) begin
      got_q.push_back({row_write, row_erase, row_eom, row_addr});
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_rows();
    repeat (3) @(posedge clk);
    chk(32'(got_q.size()), 32'(exp_q.size()), "row count");
    foreach (exp_q[i]) begin
      if (i < got_q.size()) begin
        chk(32'(got_q[i]), 32'(exp_q[i]), "row event");
      end
    end
    got_q = {};
    exp_q = {};
  endtask
  task automatic expect_range(input logic [1:0] k, input logic end_of_message_marker);
    logic [10:0] r;
    r = s;
    while (r != e) begin
      exp_q.push_back({k, 1'b0, r});
      r = (r == vrc_pkg::LAST_ROW) ? vrc_pkg::FIRST_USER_ROW : r + 11'h001;
    end
    exp_q.push_back({k, end_of_message_marker, r});
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic set_cmd(input logic [7:0] op);
    host.frame({8'h00, 5'h00, e[10:8], e[7:0], 5'h00, s[10:8], s[7:0], 8'h00, op}, 7);
  endtask
  task automatic cmd(input logic [7:0] op, input int n);
    host.frame({48'h0, op}, n);
  endtask
  task automatic wait_rows(input int n);
    while (got_q.size() < n) begin
      @(posedge clk);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #500000;
    n_errors++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} <= '0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, 8'h0c, 32'h0);
    chk(32'({err, ready, int_flag, ext_mode, irq}), 32'h18, "reset state");
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      cmd(vrc_pkg::OP_EXT_CLK, 2);
      chk(32'({ext_mode, int_flag}), 32'({i == 0, 1'b0}), "toggle");
    end
    cmd(vrc_pkg::OP_EXT_CLK, 2);
    cmd(vrc_pkg::OP_RESET, 1);
    chk(32'(ext_mode), 32'h0, "reset cmd");
    $display("timebase toggle test done");
    apb(1'b1, vrc_pkg::ADDR_IRQ_MASK, 32'h1);
    s = 11'(rnd() & 32'h3ff) + vrc_pkg::FIRST_USER_ROW;
    e = s + 11'h007;
    set_cmd(vrc_pkg::OP_RANGED_RECORD_CMD);
    cmd(vrc_pkg::OP_SET_ERASE, 7);
    cmd(vrc_pkg::OP_RD_STATUS, 1);
    chk(32'(host.last_sr0[0]), 32'h1, "error on status");
    apb(1'b0, vrc_pkg::ADDR_IRQ_STAT, 32'h0);
    chk({rd[1:0], 30'(irq)}, 32'h80000000, "masked error");
    wait_rows(8);
    expect_range(2'b10, 1'b1);
    chk_rows();
    chk(32'({ready, int_flag, irq}), 32'h7, "record done");
    cmd(vrc_pkg::OP_RD_STATUS, 1);
    chk(32'(host.last_sr0[4]), 32'h1, "int held");
    cmd(vrc_pkg::OP_INTERRUPT_CLEAR_CMD, 1);
    apb(1'b1, vrc_pkg::ADDR_IRQ_STAT, 32'h3);
    @(posedge clk);
    chk(32'({int_flag, irq}), 32'h0, "int cleared");
    $display("single record test done");
    s = 11'(rnd() & 32'h3ff) + vrc_pkg::FIRST_USER_ROW;
    e = s + 11'h005;
    set_cmd(vrc_pkg::OP_RANGED_RECORD_CMD);
    expect_range(2'b10, 1'b0);
    s = 11'h7fe;
    e = 11'h011;
    set_cmd(vrc_pkg::OP_RANGED_RECORD_CMD);
    expect_range(2'b10, 1'b1);
    wait_rows(10);
    chk_rows();
    cmd(vrc_pkg::OP_INTERRUPT_CLEAR_CMD, 1);
    $display("queued record test done");
    s = 11'(rnd() & 32'h3ff) + vrc_pkg::FIRST_USER_ROW;
    e = s + 11'h002;
    set_cmd(vrc_pkg::OP_SET_ERASE);
    wait_rows(1);
    apb(1'b0, vrc_pkg::ADDR_STATE, 32'h0);
    chk(32'(rd[20:0]), 32'({5'h01, 5'h00, s + 11'h001}), "erase state");
    chk(32'(ready), 32'h0, "busy erasing");
    cmd(vrc_pkg::OP_STOP, 1);
    apb(1'b0, vrc_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(32'(rd[vrc_pkg::IRQ_CMD_ERR]), 32'h1, "stop refused");
    wait_rows(3);
    expect_range(2'b01, 1'b0);
    chk_rows();
    chk(32'({ready, int_flag}), 32'h3, "erase done");
    cmd(vrc_pkg::OP_INTERRUPT_CLEAR_CMD, 1);
    $display("erase test done");
    s = 11'(rnd() & 32'h3ff) + vrc_pkg::FIRST_USER_ROW;
    e = s + 11'h004;
    set_cmd(vrc_pkg::OP_RANGED_RECORD_CMD);
    wait_rows(1);
    cmd(vrc_pkg::OP_STOP, 1);
    wait_rows(2);
    exp_q.push_back({2'b10, 1'b0, s});
    exp_q.push_back({2'b00, 1'b1, s + 11'h001});
    chk_rows();
    chk(32'({ready, int_flag}), 32'h2, "stopped");
    $display("stop test done");
    cmd(vrc_pkg::OP_EXT_CLK, 2);
    e = s;
    set_cmd(vrc_pkg::OP_RANGED_RECORD_CMD);
    repeat (1000) @(posedge clk);
    host.rosc_run(250);
    chk(32'(got_q.size()), 32'h0, "no early row");
    host.rosc_run(10);
    expect_range(2'b10, 1'b1);
    chk_rows();
    $display("external timebase test done");
    give_verdict();
  end
endmodule
